// ---- rtl/asseq_regs.svh ----
`ifndef ASSEQ_REGS_SVH
`define ASSEQ_REGS_SVH

// ==========================================================================
// register byte offsets (word aligned, even lane is data[15:8])
`define ASSEQ_OFF_CTRL    7'h00
`define ASSEQ_OFF_PRESC   7'h02
`define ASSEQ_OFF_CTIMER  7'h04
`define ASSEQ_OFF_RANGE   7'h06
`define ASSEQ_OFF_NEW_LO  7'h08
`define ASSEQ_OFF_NEW_HI  7'h0A
`define ASSEQ_OFF_MIS_LO  7'h0C
`define ASSEQ_OFF_MIS_HI  7'h0E
`define ASSEQ_OFF_START   7'h10
`define ASSEQ_OFF_TMASK   7'h12
`define ASSEQ_OFF_GAIN    7'h20
`define ASSEQ_OFF_MBOX    7'h40

// ==========================================================================
// control field positions
`define ASSEQ_CTRL_DIFF   0
`define ASSEQ_CTRL_TRGOUT 2
`define ASSEQ_CTRL_CHIRQ  4
`define ASSEQ_CTRL_GRPIRQ 5
`define ASSEQ_CTRL_MODE_L 8
`define ASSEQ_CTRL_MODE_H 10

// scan mode codes
`define ASSEQ_MODE_OFF    3'h0
`define ASSEQ_MODE_UCONT  3'h1
`define ASSEQ_MODE_USING  3'h2
`define ASSEQ_MODE_BCONT  3'h3

// ==========================================================================
// reset values
`define ASSEQ_RST_CTRL    16'h0000
`define ASSEQ_RST_PRESC   8'h28
`define ASSEQ_RST_CTIMER  16'h0001
`define ASSEQ_RST_GAIN    2'h0

// ==========================================================================
// timing
`define ASSEQ_CLK_MHZ     250
`define ASSEQ_TICK_MHZ    8
`define ASSEQ_IRQ_DLY_US  5
`define ASSEQ_BURST_US    15
`define ASSEQ_IRQ_CYC     (`ASSEQ_IRQ_DLY_US * `ASSEQ_CLK_MHZ)
`define ASSEQ_BURST_CYC   (`ASSEQ_BURST_US * `ASSEQ_CLK_MHZ)

`endif

// ---- rtl/asseq_pkg.sv ----
package asseq_pkg;

  // ========================================================================
  // sequencer and bus states
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_IVL,
    SQ_GAP
  } asseq_seq_t;

  typedef enum logic [1:0] {
    BS_IDLE,
    BS_WAIT,
    BS_ACK
  } asseq_bus_t;

  // ========================================================================
  // whole state of the sequencer top
  typedef struct packed {
    logic [15:0]        ctrl;
    logic [7:0]         presc;
    logic [15:0]        ctimer;
    logic [4:0]         ch_start;
    logic [4:0]         ch_end;
    logic               tmask;
    logic [31:0][1:0]   gain;
    logic [31:0][15:0]  mbox;
    logic [31:0]        newd;
    logic [31:0]        missd;
    asseq_seq_t         seq;
    logic [4:0]         chan;
    logic               half;
    logic [7:0]         acc;
    logic [7:0]         pre_cnt;
    logic [15:0]        ct_cnt;
    logic [11:0]        gap_cnt;
    logic [10:0]        irq_cnt;
    logic               irq_busy;
    logic               irq_ch_p;
    logic               irq_grp_p;
    logic [4:0]         tag;
    asseq_bus_t         bus;
    logic               b_we;
    logic [1:0]         b_be;
    logic [6:0]         b_addr;
    logic [15:0]        b_wdata;
    logic [15:0]        rdata;
    logic               ack;
    logic               conv_start;
    logic [4:0]         conv_ch;
    logic [3:0]         conv_gain;
    logic               trig_o;
    logic               trig_oe;
    logic               irq_chan;
    logic               irq_group;
    logic               trg_s1;
    logic               trg_s2;
    logic               trg_s3;
  } asseq_st_t;

endpackage : asseq_pkg

// ---- rtl/asseq_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module asseq_fifo #(
  parameter int W = 21,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } asseq_fifo_st_t;

  asseq_fifo_st_t st;
  asseq_fifo_st_t next_st;
  logic           push;
  logic           pop;

  // handshakes and flags
  assign in_ready  = st.cnt != D[AW:0];
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : asseq_fifo

`default_nettype wire

// ---- rtl/asseq_top.sv ----
// Notes on behaviour
// - trigger mask bit0 low accepts, high ignores
// - thirty-two gain registers, diff uses 0-15
// - gain code 00..11 means 1,2,4,8
// - reset clears all gain codes to unity
// - mailbox holds 32 read-only 16-bit results
// - differential continuous passes alternate mailbox halves
// - fresh result sets its new-data flag
// - overwrite before read sets missed-data flag
// - one wait state, colliding read longer
// - four mode codes: off, uniform continuous, uniform single, burst
// - uniform continuous repeats range, timer spaced
// - start by external trigger or software
// - scan mode bits zero stop scanning
// - interrupts 5 us after interval elapses
// - uniform single converts range once, timer spaced
// - uniform single differential uses lower half only
// - burst spacing 15 us, timer between groups
// - mailbox read or new start clears flags
// - prescaler at 8 MHz cascades conversion timer
`include "asseq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module asseq_top
  import asseq_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // carrier bus
  input  wire logic        bus_sel,
  input  wire logic        bus_we,
  input  wire logic [1:0]  bus_be,
  input  wire logic [6:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic [15:0]      bus_rdata,
  output logic             bus_ack,
  // external trigger pin, active low
  input  wire logic        ext_trig_n_i,
  output logic             ext_trig_n_o,
  output logic             ext_trig_n_oe,
  // converter
  output logic             conv_start,
  output logic [4:0]       conv_ch,
  output logic [3:0]       conv_gain,
  input  wire logic        adc_valid,
  input  wire logic [15:0] adc_data,
  output logic             adc_ready,
  // interrupt requests
  output logic             irq_chan,
  output logic             irq_group
);

  asseq_st_t   st;
  asseq_st_t   next_st;
  logic        fifo_valid;
  logic [20:0] fifo_data;
  logic        drain;
  logic        rd_mbox;
  logic        sw_go;
  logic        ext_go;
  logic        go;
  logic        tick;
  logic        expire;
  logic [2:0]  mode;
  logic [4:0]  b_slot;

  // ========================================================================
  // helpers
  function automatic logic [3:0] gain_factor(input logic [1:0] code);
    gain_factor = 4'h1 << code;
  endfunction : gain_factor

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0]  be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic [4:0] slot_of(input logic diff, input logic half,
                                         input logic [4:0] ch);
    slot_of = diff ? {half, ch[3:0]} : ch;
  endfunction : slot_of

  // ========================================================================
  // result buffer between converter and mailbox
  asseq_fifo #(.W(21), .D(8)) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (adc_valid),
    .in_data   ({st.tag, adc_data}),
    .in_ready  (adc_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (drain)
  );

  // ========================================================================
  // decode of the pending bus access and start conditions
  assign mode    = st.ctrl[`ASSEQ_CTRL_MODE_H:`ASSEQ_CTRL_MODE_L];
  assign rd_mbox = (st.bus == BS_WAIT) && !st.b_we && st.b_addr[6];
  assign b_slot  = st.b_addr[5:1];
  // a mailbox read of another slot holds the drain for one cycle
  assign drain   = fifo_valid &&
                   !(rd_mbox && (fifo_data[20:16] != b_slot));
  assign sw_go   = (st.bus == BS_WAIT) && st.b_we && st.b_be[0] &&
                   (st.b_addr == `ASSEQ_OFF_START) && st.b_wdata[0];
  assign ext_go  = st.trg_s3 && !st.trg_s2 && !st.tmask &&
                   !st.ctrl[`ASSEQ_CTRL_TRGOUT];
  assign go      = (sw_go || ext_go) && (st.seq == SQ_IDLE) &&
                   (mode != `ASSEQ_MODE_OFF) && (mode <= `ASSEQ_MODE_BCONT);
  // 8 MHz tick from a fractional accumulator
  assign tick    = ({1'b0, st.acc} + 9'(`ASSEQ_TICK_MHZ)) >=
                   9'(`ASSEQ_CLK_MHZ);
  assign expire  = tick && (st.pre_cnt <= 8'h01) && (st.ct_cnt <= 16'h0001);

  // ========================================================================
  // next state
  always_comb begin
    logic       fire;
    logic       last;
    logic [4:0] slot;
    fire    = 1'b0;
    last    = st.chan == st.ch_end;
    slot    = 5'h00;
    next_st = st;
    next_st.conv_start = 1'b0;
    next_st.ack        = 1'b0;
    next_st.irq_chan   = 1'b0;
    next_st.irq_group  = 1'b0;
    next_st.trig_o     = 1'b1;
    next_st.trig_oe    = st.ctrl[`ASSEQ_CTRL_TRGOUT];
    next_st.trg_s1     = ext_trig_n_i;
    next_st.trg_s2     = st.trg_s1;
    next_st.trg_s3     = st.trg_s2;
    next_st.acc        = tick ? 8'(st.acc + 8'(`ASSEQ_TICK_MHZ) -
                                   8'(`ASSEQ_CLK_MHZ))
                              : 8'(st.acc + 8'(`ASSEQ_TICK_MHZ));

    // prescaler cascaded into the conversion timer
    if (tick) begin
      if (st.pre_cnt <= 8'h01) begin
        next_st.pre_cnt = st.presc;
        next_st.ct_cnt  = st.ct_cnt - 16'h0001;
      end else begin
        next_st.pre_cnt = st.pre_cnt - 8'h01;
      end
    end

    // bus access: capture, one wait cycle, answer
    unique case (st.bus)
      BS_IDLE: begin
        if (bus_sel) begin
          next_st.bus     = BS_WAIT;
          next_st.b_we    = bus_we;
          next_st.b_be    = bus_be;
          next_st.b_addr  = {bus_addr[6:1], 1'b0};
          next_st.b_wdata = bus_wdata;
        end
      end
      BS_WAIT: begin
        if (rd_mbox && fifo_valid && fifo_data[20:16] == b_slot) begin
          next_st.bus = BS_WAIT;
        end else begin
          next_st.bus   = BS_ACK;
          next_st.ack   = 1'b1;
          next_st.rdata = 16'h0000;
          if (st.b_we) begin
            if (st.b_addr == `ASSEQ_OFF_CTRL) begin
              next_st.ctrl = merge(st.ctrl, st.b_wdata, st.b_be);
            end
            if (st.b_addr == `ASSEQ_OFF_PRESC && st.b_be[0]) begin
              next_st.presc = st.b_wdata[7:0];
            end
            if (st.b_addr == `ASSEQ_OFF_CTIMER) begin
              next_st.ctimer = merge(st.ctimer, st.b_wdata, st.b_be);
            end
            if (st.b_addr == `ASSEQ_OFF_RANGE) begin
              if (st.b_be[1]) next_st.ch_end = st.b_wdata[12:8];
              if (st.b_be[0]) next_st.ch_start = st.b_wdata[4:0];
            end
            if (st.b_addr == `ASSEQ_OFF_TMASK && st.b_be[0]) begin
              next_st.tmask = st.b_wdata[0];
            end
            if (st.b_addr[6:5] == 2'b01) begin
              if (st.b_be[1]) next_st.gain[{st.b_addr[4:1], 1'b0}] =
                                st.b_wdata[9:8];
              if (st.b_be[0]) next_st.gain[{st.b_addr[4:1], 1'b1}] =
                                st.b_wdata[1:0];
            end
          end else begin
            unique case (st.b_addr)
              `ASSEQ_OFF_CTRL:   next_st.rdata = st.ctrl;
              `ASSEQ_OFF_PRESC:  next_st.rdata = {8'h00, st.presc};
              `ASSEQ_OFF_CTIMER: next_st.rdata = st.ctimer;
              `ASSEQ_OFF_RANGE:  next_st.rdata = {3'h0, st.ch_end,
                                                  3'h0, st.ch_start};
              `ASSEQ_OFF_NEW_LO: next_st.rdata = st.newd[15:0];
              `ASSEQ_OFF_NEW_HI: next_st.rdata = st.newd[31:16];
              `ASSEQ_OFF_MIS_LO: next_st.rdata = st.missd[15:0];
              `ASSEQ_OFF_MIS_HI: next_st.rdata = st.missd[31:16];
              `ASSEQ_OFF_TMASK:  next_st.rdata = {15'h0000, st.tmask};
              default: begin
                if (st.b_addr[6]) begin
                  // a just-drained word is returned fresh
                  next_st.rdata = st.mbox[b_slot];
                  next_st.newd[b_slot]  = 1'b0;
                  next_st.missd[b_slot] = 1'b0;
                end else if (st.b_addr[6:5] == 2'b01) begin
                  next_st.rdata = {6'h00,
                                   st.gain[{st.b_addr[4:1], 1'b0}],
                                   6'h00,
                                   st.gain[{st.b_addr[4:1], 1'b1}]};
                end
              end
            endcase
          end
        end
      end
      BS_ACK: begin
        next_st.bus = BS_IDLE;
      end
    endcase

    // acquisition start clears all flags
    if (go) begin
      next_st.newd  = '0;
      next_st.missd = '0;
      next_st.chan  = st.ch_start;
      next_st.half  = 1'b0;
      next_st.trig_o = !st.ctrl[`ASSEQ_CTRL_TRGOUT];
      fire = 1'b1;
    end

    // sequencer
    unique case (st.seq)
      SQ_IDLE: begin
      end
      SQ_IVL: begin
        if (expire) begin
          next_st.irq_busy = 1'b1;
          next_st.irq_cnt  = 11'(`ASSEQ_IRQ_CYC);
          next_st.irq_ch_p = (mode != `ASSEQ_MODE_BCONT) &&
                             st.ctrl[`ASSEQ_CTRL_CHIRQ];
          next_st.irq_grp_p = (last || mode == `ASSEQ_MODE_BCONT) &&
                              st.ctrl[`ASSEQ_CTRL_GRPIRQ];
          if (mode == `ASSEQ_MODE_USING && last) begin
            next_st.seq = SQ_IDLE;
          end else if (last || mode == `ASSEQ_MODE_BCONT) begin
            next_st.chan = st.ch_start;
            next_st.half = !st.half;
            fire = 1'b1;
          end else begin
            next_st.chan = st.chan + 5'h01;
            fire = 1'b1;
          end
        end
      end
      SQ_GAP: begin
        if (st.gap_cnt <= 12'h001) begin
          next_st.chan = st.chan + 5'h01;
          fire = 1'b1;
        end else begin
          next_st.gap_cnt = st.gap_cnt - 12'h001;
        end
      end
      default: next_st.seq = SQ_IDLE;
    endcase

    // issue a conversion and schedule the next one
    if (fire) begin
      next_st.conv_start = 1'b1;
      next_st.conv_ch    = next_st.chan;
      next_st.conv_gain  = gain_factor(st.gain[next_st.chan]);
      next_st.tag        = slot_of(st.ctrl[`ASSEQ_CTRL_DIFF],
                                   next_st.half, next_st.chan);
      if (mode == `ASSEQ_MODE_BCONT && next_st.chan != st.ch_end) begin
        next_st.seq     = SQ_GAP;
        next_st.gap_cnt = 12'(`ASSEQ_BURST_CYC);
      end else begin
        next_st.seq     = SQ_IVL;
        next_st.pre_cnt = st.presc;
        next_st.ct_cnt  = st.ctimer;
        // restart the tick phase so every interval is whole
        next_st.acc     = 8'h00;
      end
    end

    // writing scan mode zero stops and rewinds
    if (mode == `ASSEQ_MODE_OFF) begin
      next_st.seq  = SQ_IDLE;
      next_st.chan = st.ch_start;
    end

    // interrupt delay; a due pulse still fires when a new expiry rearms
    if (st.irq_busy && st.irq_cnt <= 11'h001) begin
      next_st.irq_chan  = st.irq_ch_p;
      next_st.irq_group = st.irq_grp_p;
    end
    if (st.irq_busy && !(st.seq == SQ_IVL && expire)) begin
      if (st.irq_cnt <= 11'h001) begin
        next_st.irq_busy  = 1'b0;
      end else begin
        next_st.irq_cnt = st.irq_cnt - 11'h001;
      end
    end

    // mailbox write from the buffer; set wins over any clear
    if (drain) begin
      slot = fifo_data[20:16];
      next_st.mbox[slot] = fifo_data[15:0];
      next_st.newd[slot] = 1'b1;
      if (st.newd[slot]) begin
        next_st.missd[slot] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.ctrl     <= `ASSEQ_RST_CTRL;
      st.presc    <= `ASSEQ_RST_PRESC;
      st.ctimer   <= `ASSEQ_RST_CTIMER;
      st.gain     <= {32{`ASSEQ_RST_GAIN}};
      st.seq      <= SQ_IDLE;
      st.bus      <= BS_IDLE;
      st.trig_o   <= 1'b1;
      st.trg_s1   <= 1'b1;
      st.trg_s2   <= 1'b1;
      st.trg_s3   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign bus_rdata     = st.rdata;
  assign bus_ack       = st.ack;
  assign ext_trig_n_o  = st.trig_o;
  assign ext_trig_n_oe = st.trig_oe;
  assign conv_start    = st.conv_start;
  assign conv_ch       = st.conv_ch;
  assign conv_gain     = st.conv_gain;
  assign irq_chan      = st.irq_chan;
  assign irq_group     = st.irq_group;

  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_MASK_BLOCKS: assert property (
    (st.seq == SQ_IDLE && st.tmask && !sw_go) |=> !st.conv_start)
    else $error("masked trigger started a scan");
  AST_GAIN_CODE: assert property (
    st.conv_start |-> $onehot(st.conv_gain))
    else $error("gain factor not 1 2 4 or 8");
  AST_NEW_SET: assert property (
    drain |=> st.newd[$past(fifo_data[20:16])])
    else $error("new-data flag not set on mailbox write");
  AST_MISS_SET: assert property (
    (drain && st.newd[fifo_data[20:16]]) |=> st.missd[$past(fifo_data[20:16])])
    else $error("missed-data flag not set on overwrite");
  AST_ONE_WAIT: assert property (
    (st.bus == BS_IDLE && bus_sel && !bus_addr[6]) |=> !st.ack ##1 st.ack)
    else $error("register access not answered after one wait");
  AST_MBOX_BOUND: assert property (
    (st.bus == BS_IDLE && bus_sel) |-> ##[2:7] st.ack)
    else $error("mailbox read held too long");
  AST_RANGE: assert property (
    st.conv_start |-> (st.conv_ch >= st.ch_start && st.conv_ch <= st.ch_end))
    else $error("converted channel outside scan range");
  AST_STOP: assert property (
    (mode == `ASSEQ_MODE_OFF) |=> (st.seq == SQ_IDLE) ##1 !st.conv_start)
    else $error("scan did not stop on mode zero");
  AST_START_CLR: assert property (
    (go && !drain) |=> (st.newd == '0 && st.missd == '0))
    else $error("flags not cleared at acquisition start");

endmodule : asseq_top

`default_nettype wire

// ---- verif/asseq_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========
// converter stand-in: one result per start, held until taken
module asseq_adc_model (
  // clock
  input  wire logic        ref_clk,
  // conversion request
  input  wire logic        conv_start,
  input  wire logic [4:0]  conv_ch,
  // result handshake
  input  wire logic        adc_ready,
  output logic             adc_valid,
  output logic [15:0]      adc_data
);
  int         n;
  logic [4:0] ch;

  // result carries a running count and the channel converted
  initial begin
    n         = 0;
    adc_valid = 1'b0;
    adc_data  = 16'hFFFF;
    forever begin
      @(posedge ref_clk);
      if (conv_start === 1'b1) begin
        ch = conv_ch;
        repeat (20) @(posedge ref_clk);
        adc_valid <= 1'b1;
        adc_data  <= {n[10:0], ch};
        do @(posedge ref_clk); while (adc_ready !== 1'b1);
        adc_valid <= 1'b0;
        adc_data  <= ~{n[10:0], ch};  // idle data does not hold
        n++;
      end
    end
  end
endmodule : asseq_adc_model

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        bus_sel = 1'b0;
  logic        bus_we = 1'b0;
  logic [1:0]  bus_be = 2'h3;
  logic [6:0]  bus_addr = 7'h00;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata, adc_data, lat, q;
  logic        bus_ack, trig_n = 1'b1, trig_o, trig_oe, trig_pin;
  logic        conv_start, adc_valid, adc_ready, irq_chan, irq_group;
  logic [4:0]  conv_ch;
  logic [3:0]  conv_gain;
  logic [4:0]  lch[$];
  logic [3:0]  lg[$];
  int          lt[$];
  int          n_errors = 0, n_compared = 0, n_grp = 0, b, d;
  int          n_chi = 0, n_tout = 0;

  // ==========
  // clock, pin level and conversion log
  initial forever #2 ref_clk = ~ref_clk;
  assign trig_pin = trig_oe ? trig_o : trig_n;
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      lch.push_back(conv_ch);
      lg.push_back(conv_gain);
      lt.push_back(int'($time / 4));
    end
    if (irq_group === 1'b1) n_grp++;
    if (irq_chan === 1'b1) n_chi++;
    if (trig_oe === 1'b1 && trig_o === 1'b0) n_tout++;
  end

  asseq_top dut (
    .ref_clk(ref_clk), .rstn(rstn), .bus_sel(bus_sel), .bus_we(bus_we),
    .bus_be(bus_be), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .ext_trig_n_i(trig_pin),
    .ext_trig_n_o(trig_o), .ext_trig_n_oe(trig_oe),
    .conv_start(conv_start), .conv_ch(conv_ch), .conv_gain(conv_gain),
    .adc_valid(adc_valid), .adc_data(adc_data), .adc_ready(adc_ready),
    .irq_chan(irq_chan), .irq_group(irq_group));

  asseq_adc_model adc (
    .ref_clk(ref_clk), .conv_start(conv_start), .conv_ch(conv_ch),
    .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_data(adc_data));

  // ==========
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [15:0] wd);
    int k;
    @(negedge ref_clk);
    bus_sel   = 1'b1;
    bus_we    = w;
    bus_addr  = a;
    bus_wdata = wd;
    k = 0;
    // request stands until the edge that sees the answer
    do begin
      @(posedge ref_clk);
      k++;
    end while (bus_ack !== 1'b1 && k < 12);
    q   = bus_rdata;
    lat = 16'(k);
    if (bus_ack !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t bus access not answered", $time);
    end
    @(negedge ref_clk);
    bus_sel = 1'b0;
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [15:0] wd);
    bus(1'b1, a, wd);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask : rdc

  task automatic go(input logic [15:0] ctl, input int n);
    int k;
    b = lch.size();
    wr(7'h00, ctl);
    wr(7'h10, 16'h0001);
    k = 0;
    while (lch.size() < b + n && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(16'(lch.size() - b), 16'(n));
  endtask : go

  // ==========
  // scenarios
  task automatic t_regs;
    rdc(7'h20, 16'h0000);
    rdc(7'h3E, 16'h0000);
    chk(lat, 16'h0003);
    rdc(7'h12, 16'h0000);
    wr(7'h12, 16'hFFFF);
    rdc(7'h12, 16'h0001);
    wr(7'h12, 16'h0000);
    wr(7'h3E, 16'hFFFF);
    rdc(7'h3E, 16'h0303);
    rdc(7'h14, 16'h0000);
  endtask : t_regs

  task automatic t_single;
    wr(7'h22, 16'h0102);
    wr(7'h24, 16'h0300);
    wr(7'h04, 16'h0001);
    wr(7'h06, 16'h0402);
    go(16'h0230, 3);
    repeat (3000) @(posedge ref_clk);
    chk(16'(lch.size() - b), 16'h0003);
    chk(16'(n_grp), 16'h0001);
    chk(16'(n_chi), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      chk({11'h000, lch[b+i]}, 16'(2 + i));
      chk({12'h000, lg[b+i]}, 16'(2 << i));
      if (i > 0) chk(16'(lt[b+i] - lt[b+i-1]), 16'd1250);
    end
    rdc(7'h08, 16'h001C);
    d = b + 1;
    rdc(7'h46, {d[10:0], 5'h03});
    rdc(7'h08, 16'h0014);
  endtask : t_single

  task automatic t_diff;
    wr(7'h06, 16'h0000);
    go(16'h0101, 3);
    repeat (100) @(posedge ref_clk);
    wr(7'h00, 16'h0000);
    repeat (3000) @(posedge ref_clk);
    chk(16'(lch.size() - b), 16'h0003);
    rdc(7'h0C, 16'h0001);
    rdc(7'h0A, 16'h0001);
    d = b + 1;
    rdc(7'h60, {d[10:0], 5'h00});
    d = b + 2;
    rdc(7'h40, {d[10:0], 5'h00});
    rdc(7'h0C, 16'h0000);
  endtask : t_diff

  task automatic t_burst;
    wr(7'h06, 16'h0100);
    go(16'h0304, 3);
    wr(7'h00, 16'h0000);
    chk(16'(lt[b+1] - lt[b]), 16'd3750);
    chk(16'(lt[b+2] - lt[b+1]), 16'd1250);
    chk(16'(n_tout), 16'h0001);
    chk({11'h000, lch[b+1]}, 16'h0001);
    chk({11'h000, lch[b+2]}, 16'h0000);
    repeat (300) @(posedge ref_clk);
  endtask : t_burst

  task automatic t_trig(input logic [15:0] m, input int n);
    wr(7'h12, m);
    wr(7'h06, 16'h0505);
    wr(7'h00, 16'h0200);
    b = lch.size();
    @(negedge ref_clk);
    trig_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    trig_n = 1'b1;
    repeat (60) @(posedge ref_clk);
    chk(16'(lch.size() - b), 16'(n));
    chk({15'h0000, trig_oe}, 16'h0000);
    if (n > 0) chk({11'h000, lch[b]}, 16'h0005);
  endtask : t_trig

  task automatic conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ==========
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    t_regs();
    t_single();
    t_diff();
    t_burst();
    t_trig(16'h0001, 0);
    t_trig(16'h0000, 1);
    conclude();
  end

  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule : testbench

`default_nettype wire
